// file: core/ppi_pkg.sv
// Shared constants, enumerations and packed carriers for the pixel port.
// Assumes one system clock; every pin-side clock is sampled, not used as one.
//
// Behaviour
// RULE1 - Sample pixel word and qualifier each capture edge.
// RULE2 - Qualifier high discards the presented pixel word.
// RULE3 - Physical bus 32 bits narrow, 64 bits wide.
// RULE4 - Effective input width 16, 32 or 64 selectable.
// RULE5 - Demultiplex words at eight, four, two, one.
// RULE6 - Decode planar, indexed, 15-bit and 30-bit colour.
// RULE7 - Sampled blank low turns colour off after delay.
// RULE8 - Blank sequence on video clock signals flyback reset.
// RULE9 - Incoming words pass through a pixel FIFO.
// RULE10 - Auxiliary port drives eight bits and blanking.
// RULE11 - Video clock divides pixel rate, or slave input.
// RULE12 - One FIFO word per ratio pixels, safely crossed.
package ppi_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int NARROW_BUS_BITS = 32;
    localparam int WIDE_BUS_BITS = 64;
    localparam int FIFO_WORDS = 8;
    localparam int BLANK_PIPE_TICKS = 8;
    localparam int FLYBACK_EDGES = 4;
    localparam int MAX_DIV_SHIFT = 4;

    // ------------------------------------------------------------------
    // Selections
    // ------------------------------------------------------------------
    localparam logic [1:0] WIDTH_16 = 2'h0;
    localparam logic [1:0] WIDTH_32 = 2'h1;
    localparam logic [1:0] WIDTH_64 = 2'h2;

    localparam logic [1:0] RATIO_8 = 2'h0;
    localparam logic [1:0] RATIO_4 = 2'h1;
    localparam logic [1:0] RATIO_2 = 2'h2;
    localparam logic [1:0] RATIO_1 = 2'h3;

    typedef enum logic [2:0] {
        MODE_PLANAR4 = 3'h0,
        MODE_INDEX8 = 3'h1,
        MODE_LUT15 = 3'h2,
        MODE_TRUE15 = 3'h3,
        MODE_LUT30 = 3'h4,
        MODE_TRUE30 = 3'h5
    } ppi_mode_type;

    typedef enum logic [1:0] {
        ST_EMPTY = 2'b01,
        ST_HOLD = 2'b10
    } ppi_state_type;

    typedef struct packed {
        logic [1:0] width_sel;
        logic [1:0] ratio_sel;
        ppi_mode_type mode;
        logic [2:0] div_shift;
        logic slave;
    } ppi_cfg_type;

    typedef struct packed {
        logic lut;
        logic [7:0] index;
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } ppi_pixel_type;

endpackage

// file: core/ppi_top.sv
// Pixel input port: capture, FIFO, demultiplex, decode, blanking, aux port.
// Assumes the capture clock, dot clock and blank arrive asynchronously to CLK
// and are slow enough, at most a quarter of CLK, to be edge-detected.

// ----------------------------------------------------------------------
// FIFO
// ----------------------------------------------------------------------
module ppi_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
        if (flush) begin
            next_rd_ptr = next_wr_ptr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule // ppi_fifo

// ----------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------
module ppi_top #(
    parameter bit WIDE = 1'b1,
    parameter int FIFO_DEPTH = ppi_pkg::FIFO_WORDS,
    parameter int PIPE_TICKS = ppi_pkg::BLANK_PIPE_TICKS
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PIXEL_CAPTURE_CLOCK,
    input wire logic CAPTURE_QUALIFIER_N,
    input wire logic [(WIDE ? 64 : 32)-1:0] P,
    input wire logic BLANK_N,
    input wire logic DOT_RATE_CLOCK_IN,
    input wire ppi_pkg::ppi_cfg_type CFG,
    output logic DOT_RATE_CLOCK_OUT,
    output logic DOT_RATE_CLOCK_OE,
    output logic CAPTURE_READY,
    output logic PIXEL_VALID,
    output ppi_pkg::ppi_pixel_type PIXEL,
    output logic COLOUR_ON,
    output logic VERTICAL_FLYBACK,
    output logic [7:0] AUX_PIXEL_OUT,
    output logic AUX_OUT_CLOCK,
    output logic AUX_BLANKING_N
);
    import ppi_pkg::*;

    localparam int PW = WIDE ? WIDE_BUS_BITS : NARROW_BUS_BITS; // RULE3

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [63:0] mask_word(input logic [63:0] w,
                                              input logic [1:0] sel);
        case (sel)
            WIDTH_16: mask_word = {48'h0, w[15:0]};
            WIDTH_32: mask_word = {32'h0, w[31:0]};
            // Only the wide variant may open all 64 lanes.
            WIDTH_64: mask_word = WIDE ? w : {32'h0, w[31:0]};
            default: mask_word = {32'h0, w[31:0]};
        endcase
    endfunction

    function automatic logic [3:0] ratio_count(input logic [1:0] sel);
        case (sel)
            RATIO_8: ratio_count = 4'h8;
            RATIO_4: ratio_count = 4'h4;
            RATIO_2: ratio_count = 4'h2;
            default: ratio_count = 4'h1;
        endcase
    endfunction

    function automatic logic [6:0] pixel_bits(input ppi_mode_type m);
        case (m)
            MODE_PLANAR4: pixel_bits = 7'h4;
            MODE_INDEX8: pixel_bits = 7'h8;
            MODE_LUT15, MODE_TRUE15: pixel_bits = 7'h10;
            default: pixel_bits = 7'h20;
        endcase
    endfunction

    function automatic ppi_pixel_type decode(input logic [31:0] s,
                                             input ppi_mode_type m);
        ppi_pixel_type px;
        px = '0;
        case (m)
            MODE_PLANAR4: px.index = {4'h0, s[3:0]};
            MODE_INDEX8: px.index = s[7:0];
            MODE_LUT15, MODE_TRUE15: begin
                px.lut = (m == MODE_LUT15);
                px.red = {s[14:10], 5'h0};
                px.green = {s[9:5], 5'h0};
                px.blue = {s[4:0], 5'h0};
                px.index = {s[14:12], s[9:8], s[4:2]};
            end
            default: begin
                px.lut = (m == MODE_LUT30);
                px.red = s[29:20];
                px.green = s[19:10];
                px.blue = s[9:0];
                px.index = s[29:22];
            end
        endcase
        return px;
    endfunction

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    logic [PW+3:0] pin_meta;
    logic [PW+3:0] pin_sync;
    logic cap_clk_prev;
    logic dot_in_prev;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Data passes the same two stages as its capture clock, so a word is
    // taken together with the edge that launched it.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            // Idle pin levels, so that no false edge follows reset.
            pin_meta <= {4'hc, {PW{1'b0}}};
            pin_sync <= {4'hc, {PW{1'b0}}};
            cap_clk_prev <= 1'b0;
            dot_in_prev <= 1'b0;
        end else begin
            pin_meta <= {CAPTURE_QUALIFIER_N, BLANK_N, PIXEL_CAPTURE_CLOCK,
                         DOT_RATE_CLOCK_IN, P};
            pin_sync <= pin_meta;
            cap_clk_prev <= pin_sync[PW+1];
            dot_in_prev <= pin_sync[PW];
        end
    end

    logic qual_n_s;
    logic blank_n_s;
    logic cap_edge;
    logic dot_in_edge;
    assign qual_n_s = pin_sync[PW+3];
    assign blank_n_s = pin_sync[PW+2];
    assign cap_edge = pin_sync[PW+1] & ~cap_clk_prev; // RULE1
    assign dot_in_edge = pin_sync[PW] & ~dot_in_prev;

    // ------------------------------------------------------------------
    // Capture into the FIFO
    // ------------------------------------------------------------------
    logic fifo_in_valid;
    logic [63:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [63:0] fifo_out_data;
    logic flyback_pulse;

    assign fifo_in_valid = cap_edge & ~qual_n_s; // RULE2
    assign fifo_in_data = mask_word(64'(pin_sync[PW-1:0]), CFG.width_sel); // RULE4

    // A word that meets a full FIFO is lost; CAPTURE_READY warns the driver.
    ppi_fifo #(
        .WIDTH(64),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_n(rst_n),
        .flush(flyback_pulse),
        .in_valid(fifo_in_valid),
        .in_ready(CAPTURE_READY),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    ); // RULE9

    // ------------------------------------------------------------------
    // Dot-rate timing
    // ------------------------------------------------------------------
    logic [4:0] dot_cnt;
    logic dot_rate_clock_out;
    logic [2:0] div_shift;
    logic dot_rate_clock_now;
    logic video_edge;
    logic pixel_tick;

    assign div_shift = (CFG.div_shift > 3'(MAX_DIV_SHIFT))
                       ? 3'(MAX_DIV_SHIFT) : CFG.div_shift;
    assign dot_rate_clock_now = dot_cnt[div_shift]; // RULE11
    assign video_edge = CFG.slave ? dot_in_edge : (dot_rate_clock_now & ~dot_rate_clock_out);
    // The pixel rate is half of CLK so that a divide of one still toggles.
    assign pixel_tick = dot_cnt[0];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dot_cnt <= 5'h0;
            dot_rate_clock_out <= 1'b0;
        end else begin
            dot_cnt <= dot_cnt + 5'h1;
            dot_rate_clock_out <= dot_rate_clock_now;
        end
    end

    assign DOT_RATE_CLOCK_OUT = dot_rate_clock_out;
    assign DOT_RATE_CLOCK_OE = ~CFG.slave; // RULE11

    // ------------------------------------------------------------------
    // Demultiplexer
    // ------------------------------------------------------------------
    ppi_state_type state;
    ppi_state_type next_state;
    logic [63:0] word;
    logic [63:0] next_word;
    logic [3:0] remain;
    logic [3:0] next_remain;
    logic next_pixel_valid;
    ppi_pixel_type next_pixel;
    logic [6:0] bits;

    assign bits = pixel_bits(CFG.mode);

    always_comb begin
        next_state = state;
        next_word = word;
        next_remain = remain;
        next_pixel_valid = 1'b0;
        next_pixel = PIXEL;
        fifo_pop = 1'b0;
        case (state)
            ST_HOLD: begin
                if (pixel_tick) begin
                    next_pixel = decode(word[31:0], CFG.mode); // RULE6
                    next_pixel_valid = 1'b1;
                    next_word = word >> bits; // RULE5
                    next_remain = remain - 4'h1;
                    if (remain == 4'h1) begin
                        next_state = ST_EMPTY;
                    end
                end
            end
            ST_EMPTY: begin
                if (pixel_tick && fifo_out_valid) begin
                    fifo_pop = 1'b1; // RULE12
                    next_pixel = decode(fifo_out_data[31:0], CFG.mode);
                    next_pixel_valid = 1'b1;
                    next_word = fifo_out_data >> bits;
                    next_remain = ratio_count(CFG.ratio_sel) - 4'h1; // RULE5
                    if (next_remain != 4'h0) begin
                        next_state = ST_HOLD;
                    end
                end
            end
            default: next_state = ST_EMPTY;
        endcase
        if (flyback_pulse) begin
            next_state = ST_EMPTY;
            next_remain = 4'h0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_EMPTY;
            word <= 64'h0;
            remain <= 4'h0;
            PIXEL_VALID <= 1'b0;
            PIXEL <= '0;
        end else begin
            state <= next_state;
            word <= next_word;
            remain <= next_remain;
            PIXEL_VALID <= next_pixel_valid;
            PIXEL <= next_pixel;
        end
    end

    // ------------------------------------------------------------------
    // Blanking pipeline and flyback detection
    // ------------------------------------------------------------------
    logic blank_held;
    logic next_blank_held;
    logic [PIPE_TICKS-1:0] blank_pipe;
    logic [PIPE_TICKS-1:0] next_blank_pipe;
    logic [2:0] low_edges;
    logic [2:0] next_low_edges;
    logic next_flyback;

    always_comb begin
        next_blank_held = blank_held;
        next_low_edges = low_edges;
        next_flyback = 1'b0;
        if (video_edge) begin
            next_blank_held = blank_n_s; // RULE7
            if (blank_n_s) begin
                next_low_edges = 3'h0;
            end else if (low_edges != 3'(FLYBACK_EDGES)) begin
                next_low_edges = low_edges + 3'h1;
                // Fires once per flyback, then waits for blank to rise.
                next_flyback = (low_edges == 3'(FLYBACK_EDGES - 1)); // RULE8
            end
        end
        next_blank_pipe = blank_pipe;
        if (pixel_tick) begin
            next_blank_pipe = {blank_pipe[PIPE_TICKS-2:0], blank_held}; // RULE7
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            blank_held <= 1'b0;
            blank_pipe <= '0;
            low_edges <= 3'h0;
            flyback_pulse <= 1'b0;
        end else begin
            blank_held <= next_blank_held;
            blank_pipe <= next_blank_pipe;
            low_edges <= next_low_edges;
            flyback_pulse <= next_flyback;
        end
    end

    assign COLOUR_ON = blank_pipe[PIPE_TICKS-1];
    assign VERTICAL_FLYBACK = flyback_pulse;

    // ------------------------------------------------------------------
    // Auxiliary output port
    // ------------------------------------------------------------------
    // Data changes as the aux clock falls, so its rising edge is mid-eye.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            AUX_PIXEL_OUT <= 8'h0;
            AUX_BLANKING_N <= 1'b0;
            AUX_OUT_CLOCK <= 1'b0;
        end else begin
            AUX_OUT_CLOCK <= ~dot_cnt[0]; // RULE10
            if (pixel_tick) begin
                AUX_PIXEL_OUT <= next_pixel.index; // RULE10
                AUX_BLANKING_N <= blank_pipe[PIPE_TICKS-1];
            end
        end
    end
endmodule // ppi_top

// file: sim/pixel_port_input_and_blanking_test.sv
// Self-checking bench for the pixel port top with a far-side word source.
// Assumes the wide variant and a free slave video clock on its input.
module pixel_port_input_and_blanking_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ppi_pkg::*;
    localparam int PIPE = 8;
    localparam logic [63:0] WORD = 64'h8877665544332211;
    logic CLK = 1'b0;
    logic RSTN, PIXEL_CAPTURE_CLOCK, CAPTURE_QUALIFIER_N, BLANK_N;
    logic DOT_RATE_CLOCK_IN, DOT_RATE_CLOCK_OUT, DOT_RATE_CLOCK_OE;
    logic CAPTURE_READY, PIXEL_VALID, COLOUR_ON, VERTICAL_FLYBACK;
    logic AUX_OUT_CLOCK, AUX_BLANKING_N;
    logic [7:0] AUX_PIXEL_OUT;
    logic [63:0] P;
    logic [2:0] vdiv = 3'h0;
    ppi_cfg_type CFG;
    ppi_pixel_type PIXEL;
    ppi_pixel_type pix_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int flybacks = 0;

    ppi_top #(.PIPE_TICKS(PIPE)) dut (.*);
    ppi_far_end far (.*);

    always #10 CLK = ~CLK;

    always @(posedge CLK) begin
        vdiv <= vdiv + 3'h1;
        DOT_RATE_CLOCK_IN <= vdiv[2];
        if (PIXEL_VALID === 1'b1) pix_q.push_back(PIXEL);
        if (VERTICAL_FLYBACK === 1'b1) flybacks++;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task ran_out;
        error_cnt++;
        $display("ERROR %0t: wait ran out", $time);
        give_verdict();
    endtask

    task wait_pix(input int n);
        for (int i = 0; i < 900 && pix_q.size() < n; i++) @(posedge CLK);
        if (pix_q.size() < n) ran_out();
    endtask

    task wait_colour(input logic lv);
        int i;
        for (i = 0; i < 200 && COLOUR_ON !== lv; i++) @(posedge CLK);
        if (COLOUR_ON !== lv) ran_out();
    endtask

    task set_cfg(input logic [1:0] w, input logic [1:0] r, ppi_mode_type m);
        @(posedge CLK);
        CFG <= '{w, r, m, 3'h0, 1'b0};
        tick(4);
        pix_q.delete();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_decode;
        logic [1:0] ws[7] = '{WIDTH_64, WIDTH_32, WIDTH_32, WIDTH_32,
            WIDTH_16, WIDTH_64, WIDTH_32};
        logic [1:0] rs[7] = '{RATIO_8, RATIO_8, RATIO_4, RATIO_2,
            RATIO_1, RATIO_2, RATIO_1};
        ppi_mode_type ms[7] = '{MODE_INDEX8, MODE_PLANAR4, MODE_INDEX8,
            MODE_TRUE15, MODE_LUT15, MODE_TRUE30, MODE_LUT30};
        int n, b;
        logic [63:0] f;
        logic [31:0] m;
        ppi_pixel_type p;
        for (int e = 0; e < 7; e++) begin
            set_cfg(ws[e], rs[e], ms[e]);
            n = 8 >> rs[e];
            b = (ms[e] == MODE_PLANAR4) ? 4 : (ms[e] == MODE_INDEX8) ? 8 :
                (ms[e] <= MODE_TRUE15) ? 16 : 32;
            m = (32'h1 << b) - 32'h1;
            far.send(WORD, 1'b0);
            wait_pix(n);
            tick(24);
            chk(32'(pix_q.size()), 32'(n));
            for (int k = 0; k < n; k++) begin
                f = WORD >> (k * b);
                p = pix_q[k];
                if (b <= 8) chk({24'h0, p.index} & m, f[31:0] & m);
                else if (b == 16) chk({17'h0, p.red[9:5], p.green[9:5],
                    p.blue[9:5]}, {17'h0, f[14:0]});
                else chk({2'h0, p.red, p.green, p.blue},
                    {2'h0, f[29:0]});
            end
            if (e == 0) chk({24'h0, AUX_PIXEL_OUT}, 32'h88);
        end
        $display("test decode done");
    endtask

    task t_qualifier;
        set_cfg(WIDTH_64, RATIO_1, MODE_INDEX8);
        far.send(64'h5a, 1'b1);
        far.send(64'hc3, 1'b0);
        wait_pix(1);
        tick(24);
        chk(32'(pix_q.size()), 32'h1);
        chk({24'h0, pix_q[0].index}, 32'hc3);
        $display("test qualifier done");
    endtask

    task t_fill;
        logic full;
        int idle;
        full = 1'b0;
        idle = 0;
        set_cfg(WIDTH_64, RATIO_8, MODE_INDEX8);
        for (int j = 0; j < 24; j++) begin
            far.send(64'(j), 1'b0);
            if (CAPTURE_READY === 1'b0) full = 1'b1;
        end
        for (int i = 0; i < 900 && idle < 40; i++) begin
            @(posedge CLK);
            idle = (PIXEL_VALID === 1'b1) ? 0 : idle + 1;
        end
        if (idle < 40) ran_out();
        chk(32'(full), 32'h1);
        chk(32'(CAPTURE_READY), 32'h1);
        chk(32'(pix_q.size() % 8), 32'h0);
        chk(32'(pix_q.size() < 192), 32'h1);
        for (int j = 0; j < 8; j++)
            chk({24'h0, pix_q[8 * j].index}, 32'(j));
        $display("test fill done");
    endtask

    task t_blank;
        int fb0, n;
        fb0 = flybacks;
        chk(32'(COLOUR_ON), 32'h1);
        @(posedge CLK);
        BLANK_N <= 1'b0;
        for (n = 0; n < 200 && COLOUR_ON !== 1'b0; n++) @(posedge CLK);
        if (n == 200) ran_out();
        chk(32'(n >= 2 * PIPE), 32'h1);
        chk(32'(n <= 2 * PIPE + 6), 32'h1);
        tick(8);
        chk(32'(COLOUR_ON), 32'h0);
        chk(32'(AUX_BLANKING_N), 32'h0);
        chk(32'(flybacks - fb0), 32'h1);
        BLANK_N <= 1'b1;
        wait_colour(1'b1);
        tick(40);
        BLANK_N <= 1'b0;
        tick(3);
        BLANK_N <= 1'b1;
        tick(60);
        chk(32'(flybacks - fb0), 32'h1);
        $display("test blank done");
    endtask

    task t_clock;
        int n;
        @(posedge CLK);
        CFG.div_shift <= 3'h2;
        tick(20);
        for (n = 0; n < 40 && DOT_RATE_CLOCK_OUT !== 1'b0; n++) tick(1);
        if (n == 40) ran_out();
        for (n = 0; n < 40 && DOT_RATE_CLOCK_OUT !== 1'b1; n++) tick(1);
        if (n == 40) ran_out();
        for (n = 0; n < 40 && DOT_RATE_CLOCK_OUT === 1'b1; n++) tick(1);
        if (n == 40) ran_out();
        chk(32'(n), 32'h4);
        CFG.slave <= 1'b1;
        tick(2);
        chk(32'(DOT_RATE_CLOCK_OE), 32'h0);
        BLANK_N <= 1'b0;
        wait_colour(1'b0);
        BLANK_N <= 1'b1;
        wait_colour(1'b1);
        $display("test clock done");
    endtask

    initial begin
        RSTN = 1'b0;
        BLANK_N = 1'b1;
        CFG = '{WIDTH_64, RATIO_1, MODE_INDEX8, 3'h0, 1'b0};
        tick(3);
        chk(32'(CAPTURE_READY), 32'h1);
        chk(32'(PIXEL_VALID), 32'h0);
        RSTN <= 1'b1;
        tick(40);
        t_decode();
        t_qualifier();
        t_fill();
        t_blank();
        t_clock();
        give_verdict();
    end
endmodule // pixel_port_input_and_blanking_test

// file: sim/ppi_far_end.sv
// Far-side pixel source: an engine loading words into the pixel port.
// Assumes CLK is the bench clock; the load clock stands low between words.
module ppi_far_end (
    input wire logic CLK,
    output logic PIXEL_CAPTURE_CLOCK,
    output logic CAPTURE_QUALIFIER_N,
    output logic [63:0] P
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        PIXEL_CAPTURE_CLOCK = 1'b0;
        CAPTURE_QUALIFIER_N = 1'b1;
        P = 64'h0;
    end

    // Released data shows the inverse of the last word, so a late capture
    // cannot pass by luck. Calls may follow back to back as a burst.
    task automatic send(input logic [63:0] word, input logic skip);
        @(posedge CLK);
        P <= word;
        CAPTURE_QUALIFIER_N <= skip;
        repeat (2) @(posedge CLK);
        PIXEL_CAPTURE_CLOCK <= 1'b1;
        repeat (2) @(posedge CLK);
        PIXEL_CAPTURE_CLOCK <= 1'b0;
        repeat (2) @(posedge CLK);
        P <= ~word;
        CAPTURE_QUALIFIER_N <= 1'b1;
    endtask
endmodule // ppi_far_end

// file: sim/ppi_top_sva.sv
// Checker for the pixel port top; it sees the top module's ports only.
// Assumes CLK rising edge, RSTN active low, and the bind below.
module ppi_top_sva #(
    parameter int PIPE_TICKS = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic BLANK_N,
    input wire ppi_pkg::ppi_cfg_type CFG,
    input wire logic DOT_RATE_CLOCK_OE,
    input wire logic CAPTURE_READY,
    input wire logic PIXEL_VALID,
    input wire logic COLOUR_ON,
    input wire logic VERTICAL_FLYBACK,
    input wire logic AUX_OUT_CLOCK,
    input wire logic [7:0] AUX_PIXEL_OUT,
    input wire logic AUX_BLANKING_N
);
    timeunit 1ns;
    timeprecision 1ns;
    import ppi_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    oe_follow_a: assert property (DOT_RATE_CLOCK_OE == !CFG.slave)
        else $error("video clock enable does not follow slave select");
    // The first reset edge is skipped: the reset flops may start unknown.
    reset_idle_a: assert property (disable iff (1'b0)
        !RSTN ##1 !RSTN |-> CAPTURE_READY && !PIXEL_VALID && !COLOUR_ON)
        else $error("outputs not idle during reset");
    valid_gap_a: assert property (PIXEL_VALID |=> !PIXEL_VALID)
        else $error("pixels closer than two clocks");
    flyback_pulse_a: assert property (
        VERTICAL_FLYBACK |=> !VERTICAL_FLYBACK)
        else $error("flyback pulse longer than one clock");
    flyback_cause_a: assert property (
        VERTICAL_FLYBACK |-> !$past(BLANK_N, 4))
        else $error("flyback without a held blank");
    colour_delay_a: assert property (
        $fell(BLANK_N) && COLOUR_ON |=> COLOUR_ON [*8])
        else $error("colour turned off before the pipeline delay");
    colour_off_a: assert property (
        $fell(BLANK_N) ##1 !BLANK_N [*8] |-> ##[1:60] !COLOUR_ON)
        else $error("held blank did not turn colour off");
    aux_blank_a: assert property (
        $fell(AUX_BLANKING_N) |-> !$past(COLOUR_ON))
        else $error("aux blanking fell while colour was on");
    aux_clock_a: assert property (
        AUX_OUT_CLOCK |=> !AUX_OUT_CLOCK ##1 AUX_OUT_CLOCK)
        else $error("aux clock not at pixel rate");
    aux_eye_a: assert property (
        $rose(AUX_OUT_CLOCK) |-> $stable(AUX_PIXEL_OUT))
        else $error("aux data changed at the aux clock rising edge");

    cover property (PIXEL_VALID);
    cover property (VERTICAL_FLYBACK);
    cover property (!CAPTURE_READY);
endmodule // ppi_top_sva

bind ppi_top ppi_top_sva #(.PIPE_TICKS(PIPE_TICKS)) u_sva (.*);
